// File: core/indicator_bar_alarm_controller.sv
// Indicator bar controller: lamp drive, lamp check, buzzer and chime sounds.
// Assumes vehicle inputs are asynchronous pins already conditioned to active high.
//
// The address map and the strobed register port were left to the implementer.
`timescale 1ns/1ps

module indicator_bar_alarm_controller
	import tt_pkg::*;
#(
	parameter int unsigned MS_CYC_P      = MS_CYC,
	parameter int unsigned CLICK_CYC_P   = CLICK_CYC,
	parameter int unsigned SUSP_OFF_MS_P = SUSP_OFF_MS,
	parameter int unsigned CHIME_HALF_P  = CHIME_HALF,
	parameter int unsigned BUZZ_HALF_P   = BUZZ_HALF
)
(
	// Clock and reset
	input  wire logic              clk_sys_in,
	input  wire logic              resetn_in,
	// Vehicle inputs
	input  wire sens_s             sens_in,
	// Register port
	input  wire logic [7:0]        addr_in,
	input  wire logic [31:0]       wr_data_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [31:0]       rd_data_out,
	// Lamps and sound
	output logic      [LAMPS-1:0]  lamp_out,
	output logic                   buzzer_out,
	output logic                   chime_out
);

	function automatic logic at_end(input logic [31:0] cnt, input int unsigned lim);
		return cnt == 32'(lim - 1);
	endfunction

	logic [SENS_W-1:0] s1_q, s2_q, s3_q, filt_q, prev_q;
	sens_s             sv, pv;
	logic [31:0]       ctrl_q;
	logic [SPARES-1:0] spare_q;
	logic [31:0]       ms_cnt_q, flash_q;
	logic              ms_tick_q;
	logic              chk_done_q, chk_act_q;
	logic [31:0]       chk_ms_q;
	logic              low_air_q;
	susp_e             susp_st_q;
	logic [31:0]       susp_ms_q;
	logic [31:0]       click_cnt_q;
	logic [31:0]       bz_cnt_q, ct_cnt_q, pwm_q;
	logic              buzz_tone_q, chime_tone_q;
	chime_e            chime_st_q;
	logic [31:0]       ch_ms_q;
	logic              ch_left_q;
	buz_e              buz_src;
	logic [LAMPS-1:0]  lamp_d;
	logic              flash1, flash2, turn_rise, sound_en, susp_lamp;

	assign sv        = filt_q;
	assign pv        = prev_q;
	assign sound_en  = ctrl_q[CTRL_SOUND];
	assign flash1    = flash_q < 32'(PLUG_ON_MS);
	assign flash2    = (flash_q < 32'(FIRE_ON_MS)) || ((flash_q >= 32'(PLUG_ON_MS)) &&
		(flash_q < 32'(PLUG_ON_MS + FIRE_ON_MS)));
	assign turn_rise = (sv.turn_left && !pv.turn_left) || (sv.turn_right && !pv.turn_right);
	assign susp_lamp = susp_st_q == SU_ON;

	// Three-stage input sync; a change is taken once stages two and three agree
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			s1_q   <= '0;
			s2_q   <= '0;
			s3_q   <= '0;
			filt_q <= '0;
			prev_q <= '0;
		end
		else
		begin
			s1_q   <= sens_in;
			s2_q   <= s1_q;
			s3_q   <= s2_q;
			filt_q <= (s2_q & s3_q) | (filt_q & (s2_q ^ s3_q));
			prev_q <= filt_q;
		end
	end

	// Millisecond tick and 1 s flash phase
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ms_cnt_q  <= '0;
			ms_tick_q <= 1'b0;
			flash_q   <= '0;
		end
		else
		begin
			ms_tick_q <= at_end(ms_cnt_q, MS_CYC_P);
			ms_cnt_q  <= at_end(ms_cnt_q, MS_CYC_P) ? '0 : ms_cnt_q + 32'h1;
			if (ms_tick_q)
				flash_q <= at_end(flash_q, FLASH_MS) ? '0 : flash_q + 32'h1;
		end
	end

	// Tone generators
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			bz_cnt_q     <= '0;
			ct_cnt_q     <= '0;
			pwm_q        <= '0;
			buzz_tone_q  <= 1'b0;
			chime_tone_q <= 1'b0;
		end
		else
		begin
			bz_cnt_q <= at_end(bz_cnt_q, BUZZ_HALF_P) ? '0 : bz_cnt_q + 32'h1;
			if (at_end(bz_cnt_q, BUZZ_HALF_P))
				buzz_tone_q <= !buzz_tone_q;
			ct_cnt_q <= at_end(ct_cnt_q, CHIME_HALF_P) ? '0 : ct_cnt_q + 32'h1;
			if (at_end(ct_cnt_q, CHIME_HALF_P))
				chime_tone_q <= !chime_tone_q;
			pwm_q <= at_end(pwm_q, DECAY_MS) ? '0 : pwm_q + 32'h1;
		end
	end

	// Lamp check on the first ignition after reset
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			chk_done_q <= 1'b0;
			chk_act_q  <= 1'b0;
			chk_ms_q   <= '0;
		end
		else if (!chk_done_q && sv.ignition)
		begin
			chk_done_q <= 1'b1;
			chk_act_q  <= 1'b1;
			chk_ms_q   <= '0;
		end
		else if (chk_act_q && ms_tick_q)
		begin
			chk_ms_q <= at_end(chk_ms_q, LAMP_CHECK_MS) ? '0 : chk_ms_q + 32'h1;
			if (at_end(chk_ms_q, LAMP_CHECK_MS))
				chk_act_q <= 1'b0;
		end
	end

	// Low air hysteresis
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			low_air_q <= 1'b0;
		else if (sv.air_front_low || sv.air_rear_low)
			low_air_q <= 1'b1;
		else if (sv.air_front_ok && sv.air_rear_ok)
			low_air_q <= 1'b0;
	end

	// Suspension dump on and off delays
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			susp_st_q <= SU_OFF;
			susp_ms_q <= '0;
		end
		else
		begin
			case (susp_st_q)
				SU_OFF:
				begin
					if (!sv.susp_dumped)
						susp_ms_q <= '0;
					else if (ms_tick_q)
					begin
						susp_ms_q <= susp_ms_q + 32'h1;
						if (at_end(susp_ms_q, SUSP_ON_MS))
						begin
							susp_st_q <= SU_ON;
							susp_ms_q <= '0;
						end
					end
				end
				SU_ON:
				begin
					if (sv.susp_dumped)
						susp_ms_q <= '0;
					else if (ms_tick_q)
					begin
						susp_ms_q <= susp_ms_q + 32'h1;
						if (at_end(susp_ms_q, SUSP_OFF_MS_P))
						begin
							susp_st_q <= SU_OFF;
							susp_ms_q <= '0;
						end
					end
				end
				default:
				begin
					susp_st_q <= SU_OFF;
					susp_ms_q <= '0;
				end
			endcase
		end
	end

	// Turn click timer, restarted on every turn lamp turn-on
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			click_cnt_q <= '0;
		else if (turn_rise)
			click_cnt_q <= CLICK_CYC_P;
		else if (click_cnt_q != '0)
			click_cnt_q <= click_cnt_q - 32'h1;
	end

	// Chime sequencer; a request while busy is ignored
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			chime_st_q <= CH_IDLE;
			ch_ms_q    <= '0;
			ch_left_q  <= 1'b0;
		end
		else
		begin
			case (chime_st_q)
				CH_IDLE:
				begin
					ch_ms_q <= '0;
					if (sv.wc_stop_req && !pv.wc_stop_req)
					begin
						chime_st_q <= CH_FULL;
						ch_left_q  <= 1'b1;
					end
					else if (sv.stop_req && !pv.stop_req)
					begin
						chime_st_q <= CH_FULL;
						ch_left_q  <= 1'b0;
					end
				end
				CH_FULL:
				begin
					if (ms_tick_q)
					begin
						ch_ms_q <= ch_ms_q + 32'h1;
						if (at_end(ch_ms_q, FULL_MS))
						begin
							chime_st_q <= CH_DECAY;
							ch_ms_q    <= '0;
						end
					end
				end
				CH_DECAY:
				begin
					if (ms_tick_q)
					begin
						ch_ms_q <= ch_ms_q + 32'h1;
						if (at_end(ch_ms_q, DECAY_MS))
						begin
							ch_ms_q    <= '0;
							ch_left_q  <= 1'b0;
							chime_st_q <= ch_left_q ? CH_FULL : CH_IDLE;
						end
					end
				end
				default:
					chime_st_q <= CH_IDLE;
			endcase
		end
	end

	// Buzzer source by priority
	always_comb
	begin
		if (sv.fire)
			buz_src = BZ_FIRE;
		else if (low_air_q)
			buz_src = BZ_AIR;
		else if (sv.stop_engine || sv.check_engine)
			buz_src = BZ_ENG;
		else if (sv.plug_in && sv.ignition)
			buz_src = BZ_PLUG;
		else if (sv.water_filter)
			buz_src = BZ_WATER;
		else if (sv.low_coolant || sv.hyd_oil_hot || (sv.headlight_on && !sv.ignition) ||
			sv.level_warn || susp_lamp)
			buz_src = BZ_OTHER;
		else if (click_cnt_q != '0)
			buz_src = BZ_CLICK;
		else
			buz_src = BZ_NONE;
	end

	// Normal lamp indication
	always_comb
	begin
		lamp_d = '0;
		for (int i = 0; i < SPARES; i++)
			lamp_d[SPARE_LOC[i]] = spare_q[i];
		lamp_d[L_LOW_FUEL]     = sv.low_fuel;
		lamp_d[L_TRACTION]     = sv.traction_control_lamp;
		lamp_d[L_PARK_BRAKE]   = sv.park_brake;
		lamp_d[L_HIGH_BEAM]    = sv.high_beam;
		lamp_d[L_STOP_ENGINE]  = sv.stop_engine;
		lamp_d[L_WAIT_START]   = sv.wait_start;
		lamp_d[L_ENG_MAINT]    = sv.eng_maint;
		lamp_d[L_LOW_COOLANT]  = sv.low_coolant;
		lamp_d[L_TURN_LEFT]    = sv.turn_left;
		lamp_d[L_WATER]        = sv.water_filter;
		lamp_d[L_ABS]          = sv.abs_fault;
		lamp_d[L_LOW_AIR]      = low_air_q;
		lamp_d[L_ENG_BRAKE]    = sv.engine_brake;
		lamp_d[L_FIRE]         = sv.fire;
		lamp_d[L_TRANS_TEMP]   = sv.trans_temp;
		lamp_d[L_CHECK_ENGINE] = sv.check_engine;
		lamp_d[L_HYD_OIL]      = sv.hyd_oil_hot;
		lamp_d[L_TURN_RIGHT]   = sv.turn_right;
		lamp_d[L_DAYTIME]      = sv.daytime_running_lamp;
		lamp_d[L_HEADLIGHT]    = sv.headlight_on && !sv.ignition;
		lamp_d[L_LEVEL]        = sv.level_warn;
		lamp_d[L_SUSP]         = susp_lamp;
		lamp_d[L_TAG]          = sv.tag_dump;
		lamp_d[L_CHECK_TRANS]  = sv.check_trans;
		lamp_d[L_PLUG]         = sv.plug_in && sv.ignition && flash1;
	end

	// Output stage
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			lamp_out   <= '0;
			buzzer_out <= 1'b0;
			chime_out  <= 1'b0;
		end
		else
		begin
			lamp_out <= chk_act_q ? '1 : lamp_d;
			case (buz_src)
				BZ_FIRE:  buzzer_out <= sound_en && buzz_tone_q && flash2;
				BZ_PLUG:  buzzer_out <= sound_en && buzz_tone_q && flash1;
				BZ_CLICK: buzzer_out <= sound_en;
				BZ_NONE:  buzzer_out <= 1'b0;
				default:  buzzer_out <= sound_en && buzz_tone_q;
			endcase
			chime_out <= sound_en && chime_tone_q && ((chime_st_q == CH_FULL) ||
				((chime_st_q == CH_DECAY) && (pwm_q < 32'(DECAY_MS) - ch_ms_q)));
		end
	end

	// Register port
	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
		begin
			ctrl_q  <= CTRL_RST;
			spare_q <= '0;
		end
		else if (wr_in)
		begin
			if (addr_in == REG_CTRL)
				ctrl_q <= {31'h0, wr_data_in[CTRL_SOUND]};
			if (addr_in == REG_SPARE)
				spare_q <= wr_data_in[SPARES-1:0];
		end
	end

	always_ff @(posedge clk_sys_in or negedge resetn_in)
	begin
		if (!resetn_in)
			rd_data_out <= '0;
		else if (!rd_in)
			rd_data_out <= '0;
		else
		begin
			case (addr_in)
				REG_CTRL:     rd_data_out <= ctrl_q;
				REG_SPARE:    rd_data_out <= {{(32 - SPARES){1'b0}}, spare_q};
				REG_STATUS:   rd_data_out <= {24'h0, chime_st_q != CH_IDLE, buz_src, 1'b0, susp_lamp,
					low_air_q, chk_act_q};
				REG_LAMPS_LO: rd_data_out <= lamp_out[31:0];
				REG_LAMPS_HI: rd_data_out <= {30'h0, lamp_out[LAMPS-1:32]};
				default:      rd_data_out <= '0;
			endcase
		end
	end

	// Checks
	default clocking cb @(posedge clk_sys_in); endclocking
	default disable iff (!resetn_in);

	sequence wc_start_s;
		chime_st_q == CH_IDLE && sv.wc_stop_req && !pv.wc_stop_req;
	endsequence

	lamp_check_a: assert property (chk_act_q |=> lamp_out == '1)
		else $error("lamp check not lighting all lamps");
	check_len_a: assert property (chk_ms_q < 32'(LAMP_CHECK_MS))
		else $error("lamp check overran");
	click_load_a: assert property (turn_rise |=> click_cnt_q == CLICK_CYC_P)
		else $error("click not started on turn lamp");
	fire_prio_a: assert property (sv.fire |-> buz_src == BZ_FIRE)
		else $error("fire alarm not at top priority");
	fire_pulse_a: assert property (buz_src == BZ_FIRE && !flash2 |=> !buzzer_out)
		else $error("fire buzzer sounding in off phase");
	low_air_hold_a: assert property (low_air_q && !(sv.air_front_ok && sv.air_rear_ok) |=> low_air_q)
		else $error("low air released early");
	chime_quiet_a: assert property (chime_st_q == CH_IDLE |=> !chime_out)
		else $error("chime sounding while idle");
	double_chime_a: assert property (wc_start_s |=> chime_st_q == CH_FULL && ch_left_q)
		else $error("wheelchair request not queuing two chimes");
	buzz_half_a: assert property ($changed(buzz_tone_q) |-> $past(bz_cnt_q) == 32'(BUZZ_HALF_P - 1))
		else $error("buzzer tone half period wrong");
	silent_a: assert property (buz_src == BZ_NONE |=> !buzzer_out)
		else $error("buzzer on with no alarm");

endmodule

// File: core/tt_pkg.sv
// Constants, field layouts and types for the indicator bar alarm controller.
// Assumes a single 125 MHz system clock; every time is a count of it or of the 1 ms tick made from it.
package tt_pkg;

	// Clock and lamp count
	localparam int unsigned CLK_HZ        = 125_000_000;
	localparam int unsigned LAMPS         = 34;
	localparam int unsigned MS_CYC        = CLK_HZ / 1000;

	// Times in their own units
	localparam int unsigned LAMP_CHECK_S  = 2;
	localparam int unsigned CLICK_MS      = 10;
	localparam int unsigned CHIME_MS      = 1000;
	localparam int unsigned DECAY_MS      = 800;
	localparam int unsigned SUSP_ON_S     = 2;
	localparam int unsigned SUSP_OFF_MIN  = 1;
	localparam int unsigned CHIME_HZ      = 1000;
	localparam int unsigned BUZZ_HZ       = 3600;
	localparam int unsigned PLUG_FLASH_HZ = 1;
	localparam int unsigned FIRE_FLASH_HZ = 2;

	// Derived counts (ms ticks or clock cycles)
	localparam int unsigned LAMP_CHECK_MS = LAMP_CHECK_S * 1000;
	localparam int unsigned FULL_MS       = CHIME_MS - DECAY_MS;
	localparam int unsigned SUSP_ON_MS    = SUSP_ON_S * 1000;
	localparam int unsigned SUSP_OFF_MS   = SUSP_OFF_MIN * 60_000;
	localparam int unsigned CLICK_CYC     = CLICK_MS * MS_CYC;
	localparam int unsigned CHIME_HALF    = CLK_HZ / (2 * CHIME_HZ);
	localparam int unsigned BUZZ_HALF     = CLK_HZ / (2 * BUZZ_HZ);
	localparam int unsigned FLASH_MS      = 1000 / PLUG_FLASH_HZ;
	localparam int unsigned PLUG_ON_MS    = FLASH_MS / 2;
	localparam int unsigned FIRE_ON_MS    = 1000 / FIRE_FLASH_HZ / 2;

	// Lamp positions (location number minus one)
	localparam int unsigned L_LOW_FUEL = 2, L_TRACTION = 3, L_PARK_BRAKE = 4, L_HIGH_BEAM = 5,
		L_STOP_ENGINE = 6, L_WAIT_START = 7, L_ENG_MAINT = 8, L_LOW_COOLANT = 9, L_TURN_LEFT = 11,
		L_WATER = 13, L_ABS = 14, L_LOW_AIR = 15, L_ENG_BRAKE = 16, L_FIRE = 17, L_TRANS_TEMP = 18,
		L_CHECK_ENGINE = 19, L_HYD_OIL = 20, L_TURN_RIGHT = 22, L_DAYTIME = 23, L_HEADLIGHT = 26,
		L_LEVEL = 27, L_SUSP = 28, L_TAG = 29, L_CHECK_TRANS = 30, L_PLUG = 31;
	localparam int unsigned SPARES = 9;
	localparam int unsigned SPARE_LOC [SPARES] = '{0, 1, 10, 12, 21, 24, 25, 32, 33};

	// Register map
	localparam logic [7:0]  REG_CTRL     = 8'h00;
	localparam logic [7:0]  REG_SPARE    = 8'h04;
	localparam logic [7:0]  REG_STATUS   = 8'h08;
	localparam logic [7:0]  REG_LAMPS_LO = 8'h0C;
	localparam logic [7:0]  REG_LAMPS_HI = 8'h10;
	localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
	localparam int unsigned CTRL_SOUND   = 0;

	// Conditioned vehicle inputs, all active high
	typedef struct packed {
		logic ignition;
		logic stop_req;
		logic wc_stop_req;
		logic low_fuel;
		logic traction_control_lamp;
		logic park_brake;
		logic high_beam;
		logic stop_engine;
		logic wait_start;
		logic eng_maint;
		logic low_coolant;
		logic turn_left;
		logic water_filter;
		logic abs_fault;
		logic air_front_low;
		logic air_rear_low;
		logic air_front_ok;
		logic air_rear_ok;
		logic engine_brake;
		logic fire;
		logic trans_temp;
		logic check_engine;
		logic hyd_oil_hot;
		logic turn_right;
		logic daytime_running_lamp;
		logic headlight_on;
		logic level_warn;
		logic susp_dumped;
		logic tag_dump;
		logic check_trans;
		logic plug_in;
	} sens_s;
	localparam int unsigned SENS_W = $bits(sens_s);

	typedef enum logic [2:0] {BZ_NONE, BZ_FIRE, BZ_AIR, BZ_ENG, BZ_PLUG, BZ_WATER, BZ_OTHER, BZ_CLICK} buz_e;
	typedef enum logic [1:0] {CH_IDLE, CH_FULL, CH_DECAY} chime_e;
	typedef enum logic [1:0] {SU_OFF, SU_ON} susp_e;

endpackage

// File: test/tb.sv
// Bench for the indicator bar controller: register tasks, vehicle model, sound counts.
// Assumes shortened counts: 1 ms is 10 clocks, click 100, tone half periods 3 and 5.
`timescale 1ns/1ps
module tb
	import tt_pkg::*;
;
	localparam int NT = 10;
	localparam int T_BIT [NT] = '{23, 9, 0, 18, 20, 8, 4, 5, 27, 25};
	localparam int T_LMP [NT] = '{L_STOP_ENGINE, L_CHECK_ENGINE, L_PLUG, L_WATER, L_LOW_COOLANT,
		L_HYD_OIL, L_LEVEL, L_HEADLIGHT, L_LOW_FUEL, L_PARK_BRAKE};
	localparam int T_SRC [NT] = '{3, 3, 4, 5, 6, 6, 6, 6, 0, 0};

	logic             clk_sys_in = 1'b0;
	logic             resetn_in  = 1'b0;
	sens_s            want       = '0;
	sens_s            sens;
	sens_s            s;
	logic [7:0]       addr       = 8'h00;
	logic [31:0]      wdata      = 32'h0000_0000;
	logic             wr         = 1'b0;
	logic             rd         = 1'b0;
	logic [31:0]      rdata;
	logic [31:0]      rv;
	logic [LAMPS-1:0] lamp;
	logic             buz;
	logic             chime;
	int               n_mismatch = 0;
	int               checks     = 0;
	int               c;
	int               kb         = 0;

	always #4 clk_sys_in = ~clk_sys_in;

	vehicle_model u_veh (.clk_sys_in(clk_sys_in), .want_in(want), .sens_out(sens));

	indicator_bar_alarm_controller #(.MS_CYC_P(10), .CLICK_CYC_P(100), .SUSP_OFF_MS_P(50),
		.CHIME_HALF_P(5), .BUZZ_HALF_P(3)) u_dut (
		.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .sens_in(sens), .addr_in(addr),
		.wr_data_in(wdata), .wr_in(wr), .rd_in(rd), .rd_data_out(rdata), .lamp_out(lamp),
		.buzzer_out(buz), .chime_out(chime));

	// Waits whole cycles and lands just after the last edge
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_sys_in);
		#1;
	endtask

	task automatic put(input sens_s v);
		@(posedge clk_sys_in);
		want <= v;
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk_sys_in);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
		@(posedge clk_sys_in);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk_sys_in);
		rd <= 1'b0;
		#1;
		d = rdata;
	endtask

	task automatic cmp(input logic [33:0] got, input logic [33:0] exp, input string w);
		checks++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s got %h expected %h", $time, w, got, exp);
		end
	endtask

	task automatic cmp_rng(input int got, input int lo, input int hi, input string w);
		checks++;
		if (got < lo || got > hi)
		begin
			n_mismatch++;
			$display("wrong value at %0t: %s count %0d outside %0d..%0d", $time, w, got, lo, hi);
		end
	endtask

	// High cycles of buzzer (0), chime (1) or plug lamp (2); kb counts the buzzer alongside
	task automatic count(input int n, input int sel, output int k);
		logic b;
		k = 0;
		kb = 0;
		repeat (n)
		begin
			cyc(1);
			b = sel == 0 ? buz : sel == 1 ? chime : lamp[L_PLUG];
			if ($isunknown(b) || $isunknown(buz))
				cmp({b, buz}, 0, "unknown sound output");
			k += int'(b);
			kb += int'(buz);
		end
	endtask

	task automatic src_is(input logic [2:0] e);
		rd_reg(REG_STATUS, rv);
		cmp(rv[6:4], e, "buzzer source");
	endtask

	task automatic endt(input string n);
		$display("test %s done", n);
	endtask

	task automatic finish_test();
		$display("comparisons %0d mismatches %0d", checks, n_mismatch);
		if (n_mismatch == 0 && checks > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	initial
	begin
		repeat (5) @(posedge clk_sys_in);
		resetn_in <= 1'b1;
		rd_reg(REG_CTRL, rv);
		cmp(rv, CTRL_RST, "ctrl reset");
		rd_reg(REG_SPARE, rv);
		cmp(rv, 0, "spare reset");
		rd_reg(8'h14, rv);
		cmp(rv, 0, "unmapped read");
		wr_reg(REG_STATUS, 32'hFFFF_FFFF);
		rd_reg(REG_STATUS, rv);
		cmp(rv, 0, "status read only");
		wr_reg(REG_SPARE, 32'h0000_01FF);
		cyc(2);
		cmp(lamp, 34'h3_0320_1403, "spare lamps");
		wr_reg(REG_SPARE, 32'h0000_0000);
		endt("registers");

		s = '0;
		s.ignition = 1'b1;
		put(s);
		c = 0;
		while (lamp !== '1 && c < 20)
		begin
			cyc(1);
			c++;
		end
		if (c == 20)
		begin
			n_mismatch++;
			$display("wrong value at %0t: lamp check never started", $time);
			finish_test();
		end
		cmp(lamp, '1, "lamp check on");
		rd_reg(REG_LAMPS_LO, rv);
		cmp(rv, 32'hFFFF_FFFF, "lamps low");
		rd_reg(REG_LAMPS_HI, rv);
		cmp(rv, 32'h0000_0003, "lamps high");
		cyc(19700);
		cmp(lamp, '1, "lamp check held");
		cyc(500);
		cmp(lamp, 0, "lamp check over");
		endt("lamp check");

		for (int i = 0; i < NT; i++)
		begin
			s = '0;
			s.ignition = (T_LMP[i] != L_HEADLIGHT);
			s[T_BIT[i]] = 1'b1;
			put(s);
			cyc(10);
			if (T_LMP[i] != L_PLUG)
				cmp(lamp[T_LMP[i]], 1, "alarm lamp");
			src_is(3'(T_SRC[i]));
			count(60, 0, c);
			if (T_SRC[i] != 4)
				cmp_rng(c, T_SRC[i] ? 30 : 0, T_SRC[i] ? 30 : 0, "tone");
		end
		s = '0;
		s.ignition = 1'b1;
		s.water_filter = 1'b1;
		put(s);
		wr_reg(REG_CTRL, 32'h0000_0000);
		cyc(10);
		count(60, 0, c);
		cmp_rng(c, 0, 0, "muted");
		wr_reg(REG_CTRL, CTRL_RST);
		endt("alarm table");

		s = '0;
		s.ignition = 1'b1;
		s.fire = 1'b1;
		s.air_front_low = 1'b1;
		s.check_engine = 1'b1;
		put(s);
		cyc(10);
		cmp({lamp[L_FIRE], lamp[L_LOW_AIR]}, 2'b11, "fire and air lamps");
		src_is(3'd1);
		count(5000, 0, c);
		cmp_rng(c, 1240, 1260, "fire pulse");
		s.fire = 1'b0;
		put(s);
		cyc(10);
		src_is(3'd2);
		s.air_front_low = 1'b0;
		put(s);
		cyc(10);
		cmp(lamp[L_LOW_AIR], 1, "air held");
		src_is(3'd2);
		s.air_front_ok = 1'b1;
		put(s);
		cyc(10);
		cmp(lamp[L_LOW_AIR], 1, "air one ok");
		s.air_rear_ok = 1'b1;
		put(s);
		cyc(10);
		cmp(lamp[L_LOW_AIR], 0, "air both ok");
		src_is(3'd3);
		endt("priority");

		s = '0;
		s.ignition = 1'b1;
		put(s);
		cyc(10);
		s.turn_left = 1'b1;
		put(s);
		count(300, 0, c);
		cmp_rng(c, 100, 100, "left click");
		cmp(lamp[L_TURN_LEFT], 1, "left lamp");
		s.turn_left = 1'b0;
		s.turn_right = 1'b1;
		put(s);
		count(300, 0, c);
		cmp_rng(c, 100, 100, "right click");
		cmp(lamp[L_TURN_RIGHT], 1, "right lamp");
		endt("click");

		s.turn_right = 1'b0;
		s.stop_req = 1'b1;
		put(s);
		count(100, 1, c);
		count(1000, 1, c);
		cmp_rng(c, 500, 500, "chime tone");
		cyc(7300);
		count(1000, 1, c);
		cmp_rng(c, 1, 249, "chime decay");
		rd_reg(REG_STATUS, rv);
		cmp(rv[7], 1, "chime busy");
		cyc(700);
		rd_reg(REG_STATUS, rv);
		cmp(rv[7], 0, "chime done");
		count(100, 1, c);
		cmp_rng(c, 0, 0, "chime silent");
		s.stop_req = 1'b0;
		s.wc_stop_req = 1'b1;
		put(s);
		cyc(10100);
		count(1000, 1, c);
		cmp_rng(c, 500, 500, "second chime");
		cyc(8300);
		rd_reg(REG_STATUS, rv);
		cmp(rv[7], 1, "double busy");
		cyc(900);
		rd_reg(REG_STATUS, rv);
		cmp(rv[7], 0, "double done");
		endt("chime");

		s = '0;
		s.ignition = 1'b1;
		s.susp_dumped = 1'b1;
		put(s);
		cyc(19900);
		cmp(lamp[L_SUSP], 0, "susp early");
		cyc(200);
		cmp(lamp[L_SUSP], 1, "susp on");
		s.susp_dumped = 1'b0;
		put(s);
		cyc(450);
		cmp(lamp[L_SUSP], 1, "susp held");
		cyc(100);
		cmp(lamp[L_SUSP], 0, "susp off");
		endt("suspension");

		s.plug_in = 1'b1;
		put(s);
		cyc(10);
		count(10000, 2, c);
		cmp_rng(c, 4990, 5010, "plug flash");
		cmp_rng(kb, 2490, 2510, "plug buzzer");
		endt("plug");
		finish_test();
	end
endmodule

// File: test/vehicle_model.sv
// Far side model: vehicle switches and modules as conditioned active high levels.
// Assumes the bench sets the wanted levels; they reach the pins one clock edge later.
`timescale 1ns/1ps
module vehicle_model
	import tt_pkg::*;
(
	// Clock
	input  wire logic  clk_sys_in,
	// Wanted levels
	input  wire sens_s want_in,
	// Pins
	output sens_s      sens_out
);
	initial sens_out = '0;

	always @(posedge clk_sys_in)
	begin
		sens_out <= want_in;
	end
endmodule
